// >>> rtl/prog_space_pkg.sv
// What this block does
// - PC steps by two per program word
// - Low word read passes P15..0 to D15..0
// - Low byte read selects P7..0 or P15..8
// - High word read gives P23..16, upper zero
// - High byte read gives P23..16 or zero
// - Upper program byte only via high table ops
// - Low table ops address program space directly
// - Upper data half maps to one program page
// - Redirect only when EA msb and enable set
// - Page register supplies program bits 22..15
// - Visibility reads return low 16 bits only
// - Visibility mapping off during table operations
// - Outside repeat: one or two extra cycles
// - Inside repeat: two extra at edges, else none
// - Upper data half belongs to X unless visibility is enabled
// - Y contained in X, contiguous linear range
// - MAC reads exclude Y from X block
// - MAC uses Y pointers for Y, X pointers for X
// - Concurrent X and Y reads only for MAC
// - Table page bit 7 selects configuration space
package prog_space_pkg;

    // Register byte offsets
    localparam logic [3:0] CORE_CONTROL_OFS = 4'h0;
    localparam logic [3:0] PAGE_WINDOW_OFS  = 4'h4;
    localparam logic [3:0] TABLE_PAGE_OFS   = 4'h8;
    localparam logic [3:0] LAST_ADDR_OFS    = 4'hc;

    // Field positions and reset values
    localparam int          VIS_ENABLE_BIT   = 0;
    localparam int          CFG_SPACE_BIT    = 7;
    localparam logic [7:0]  CORE_CONTROL_RST = 8'h00;
    localparam logic [7:0]  PAGE_WINDOW_RST  = 8'h00;
    localparam logic [7:0]  TABLE_PAGE_RST   = 8'h00;
    localparam logic [22:0] PC_RST           = 23'h000000;
    localparam logic [22:0] PC_STEP          = 23'h000002;

    // Data space layout, Y block inside the 256 byte space
    localparam logic [15:0] DATA_SPACE_END = 16'h00ff;
    localparam logic [15:0] Y_BASE         = 16'h0080;
    localparam logic [15:0] Y_END          = 16'h00ff;

    // Visibility penalties in cycles
    localparam logic [1:0] PEN_NONE  = 2'h0;
    localparam logic [1:0] PEN_SHORT = 2'h1;
    localparam logic [1:0] PEN_LONG  = 2'h2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        OP_DATA_RD = 3'h0,
        OP_DATA_WR = 3'h1,
        OP_TRD_LO  = 3'h2,
        OP_TRD_HI  = 3'h3,
        OP_TWR_LO  = 3'h4,
        OP_TWR_HI  = 3'h5
    } op_type;

    // Instruction class for visibility penalty
    typedef enum logic [1:0] {
        CLS_MAC_PREFETCH = 2'h0,
        CLS_MOVE         = 2'h1,
        CLS_DOUBLE_MOVE  = 2'h2,
        CLS_OTHER        = 2'h3
    } cls_type;

    // Pointer used by a MAC read
    typedef enum logic [1:0] {
        PTR_X_A = 2'h0,
        PTR_X_B = 2'h1,
        PTR_Y_A = 2'h2,
        PTR_Y_B = 2'h3
    } ptr_type;

    typedef struct packed {
        op_type      op;
        logic        byte_mode;
        logic [15:0] ea;
        logic [15:0] wdata;
        logic        mac;
        ptr_type     ptr;
        cls_type     cls;
        logic        in_repeat;
        logic        rpt_edge;
    } req_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } rsp_type;

    typedef struct packed {
        logic        x_en;
        logic        y_en;
        logic        force_zero;
        logic        visibility_enable;
        logic [1:0]  extra;
    } route_type;

endpackage : prog_space_pkg

// >>> rtl/prog_space_access.sv
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module prog_space_access (
    // Clock and reset
    input  wire logic                       i_clk,
    input  wire logic                       i_sys_rst,
    // Program counter control
    input  wire logic                       i_pc_step,
    input  wire logic                       i_pc_load,
    input  wire logic [22:0]                i_pc_value,
    output var  logic [22:0]                o_pc,
    // Core request, one per cycle
    input  wire logic                       i_req_valid,
    input  wire prog_space_pkg::req_type    i_req,
    output var  prog_space_pkg::route_type  o_route,
    output var  prog_space_pkg::rsp_type    o_rsp,
    // Program memory, read data one cycle after address
    output var  logic [23:0]                o_pm_addr,
    output var  logic                       o_pm_rd,
    output var  logic                       o_pm_wr,
    output var  logic [2:0]                 o_pm_be,
    output var  logic [23:0]                o_pm_wdata,
    output var  logic                       o_pm_cfg,
    input  wire logic [23:0]                i_pm_rdata,
    // AXI4-Lite write
    input  wire logic                       s_axi_awvalid,
    output var  logic                       s_axi_awready,
    input  wire logic [3:0]                 s_axi_awaddr,
    input  wire logic                       s_axi_wvalid,
    output var  logic                       s_axi_wready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    output var  logic                       s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    output var  logic [1:0]                 s_axi_bresp,
    // AXI4-Lite read
    input  wire logic                       s_axi_arvalid,
    output var  logic                       s_axi_arready,
    input  wire logic [3:0]                 s_axi_araddr,
    output var  logic                       s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output var  logic [31:0]                s_axi_rdata,
    output var  logic [1:0]                 s_axi_rresp
);

    // Visibility penalty by class and repeat position
    function automatic logic [1:0] psv_penalty(input prog_space_pkg::cls_type cls,
                                               input logic in_rpt, input logic rpt_edge);
        logic [1:0] pen;
        pen = prog_space_pkg::PEN_LONG;
        if (in_rpt) begin
            pen = rpt_edge ? prog_space_pkg::PEN_LONG : prog_space_pkg::PEN_NONE;
        end else if (cls != prog_space_pkg::CLS_OTHER) begin
            pen = prog_space_pkg::PEN_SHORT;
        end
        return pen;
    endfunction : psv_penalty

    // Inside the Y block
    function automatic logic in_y(input logic [15:0] ea);
        return (ea >= prog_space_pkg::Y_BASE) && (ea <= prog_space_pkg::Y_END);
    endfunction : in_y

    // Registers
    logic [7:0]  core_ctl_q;
    logic [7:0]  page_win_q;
    logic [7:0]  tbl_page_q;
    logic [23:0] last_addr_q;
    logic [22:0] pc_q;
    logic        aw_held_q;
    logic        w_held_q;
    logic [3:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        rd_pend_q;
    logic        rd_hi_q;
    logic        rd_byte_q;
    logic        rd_sel_q;

    // Request decode
    wire prog_space_pkg::op_type op = i_req.op;
    wire logic is_data  = (op == prog_space_pkg::OP_DATA_RD) || (op == prog_space_pkg::OP_DATA_WR);
    wire logic is_trd   = (op == prog_space_pkg::OP_TRD_LO) || (op == prog_space_pkg::OP_TRD_HI);
    wire logic is_twr   = (op == prog_space_pkg::OP_TWR_LO) || (op == prog_space_pkg::OP_TWR_HI);
    wire logic is_table = is_trd || is_twr;
    wire logic is_hi    = (op == prog_space_pkg::OP_TRD_HI) || (op == prog_space_pkg::OP_TWR_HI);
    wire logic vis_en   = core_ctl_q[prog_space_pkg::VIS_ENABLE_BIT];
    wire logic byte_sel = i_req.ea[0];

    // Redirect upper data half into program space
    wire logic psv_hit = i_req_valid && is_data && !is_table && i_req.ea[15] && vis_en;
    wire logic psv_rd  = psv_hit && (op == prog_space_pkg::OP_DATA_RD);

    // Program addresses
    wire logic [23:0] psv_addr = {1'b0, page_win_q, i_req.ea[14:0]};
    wire logic [23:0] tbl_addr = {tbl_page_q, i_req.ea};
    wire logic [23:0] pm_addr_d = is_table ? tbl_addr : psv_addr;
    wire logic tbl_cfg = tbl_page_q[prog_space_pkg::CFG_SPACE_BIT];

    // Table write lanes; a high byte with select one hits the phantom byte
    wire logic [2:0] be_lo = i_req.byte_mode ? (byte_sel ? 3'h2 : 3'h1) : 3'h3;
    wire logic [2:0] be_hi = (i_req.byte_mode && byte_sel) ? 3'h0 : 3'h4;
    wire logic [2:0] pm_be_d = is_hi ? be_hi : be_lo;
    wire logic [7:0] wr_byte = (i_req.byte_mode && byte_sel) ? i_req.wdata[15:8] : i_req.wdata[7:0];
    wire logic [23:0] pm_wdata_d = is_hi ? {i_req.wdata[7:0], 16'h0000}
                                         : (i_req.byte_mode ? {8'h00, wr_byte, wr_byte} : {8'h00, i_req.wdata});

    // X/Y routing for data accesses not taken by the visibility window, upper half included when it is off
    wire logic ea_high   = i_req.ea[15];
    wire logic ea_y      = !ea_high && in_y(i_req.ea);
    wire logic ea_mapped = ea_high || (i_req.ea <= prog_space_pkg::DATA_SPACE_END);
    wire logic ptr_is_y  = (i_req.ptr == prog_space_pkg::PTR_Y_A) || (i_req.ptr == prog_space_pkg::PTR_Y_B);
    wire logic mac_rd    = i_req.mac && (op == prog_space_pkg::OP_DATA_RD);
    // MAC read through the wrong pointer pair returns zero
    wire logic mac_wrong = mac_rd && (ptr_is_y ? !ea_y : ea_y);
    wire logic y_use     = mac_rd && ptr_is_y && ea_y;
    wire logic x_use     = i_req_valid && is_data && !y_use && !mac_wrong && !psv_hit && ea_mapped;

    // Steering of returned program word
    wire logic [7:0]  lo_byte  = rd_sel_q ? i_pm_rdata[15:8] : i_pm_rdata[7:0];
    wire logic [7:0]  hi_byte  = rd_sel_q ? 8'h00 : i_pm_rdata[23:16];
    wire logic [15:0] lo_data  = rd_byte_q ? {8'h00, lo_byte} : i_pm_rdata[15:0];
    wire logic [15:0] hi_data  = rd_byte_q ? {8'h00, hi_byte} : {8'h00, i_pm_rdata[23:16]};
    wire logic [15:0] rd_steer = rd_hi_q ? hi_data : lo_data;

    // Program counter, two per instruction word
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pc_q <= prog_space_pkg::PC_RST;
        end else if (i_pc_load) begin
            pc_q <= {i_pc_value[22:1], 1'b0};
        end else if (i_pc_step) begin
            pc_q <= pc_q + prog_space_pkg::PC_STEP;
        end
    end

    // Program memory request stage
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_pm_addr  <= 24'h000000;
            o_pm_rd    <= 1'b0;
            o_pm_wr    <= 1'b0;
            o_pm_be    <= 3'h0;
            o_pm_wdata <= 24'h000000;
            o_pm_cfg   <= 1'b0;
            rd_pend_q  <= 1'b0;
            rd_hi_q    <= 1'b0;
            rd_byte_q  <= 1'b0;
            rd_sel_q   <= 1'b0;
        end else begin
            o_pm_addr  <= pm_addr_d;
            o_pm_rd    <= i_req_valid && (is_trd || psv_rd);
            o_pm_wr    <= i_req_valid && is_twr;
            o_pm_be    <= (i_req_valid && is_twr) ? pm_be_d : 3'h0;
            o_pm_wdata <= pm_wdata_d;
            o_pm_cfg   <= i_req_valid && is_table && tbl_cfg;
            rd_pend_q  <= i_req_valid && (is_trd || psv_rd);
            rd_hi_q    <= is_table && is_hi;
            rd_byte_q  <= is_table && i_req.byte_mode;
            rd_sel_q   <= byte_sel;
        end
    end

    // Routing and penalty, one cycle after the request
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_route <= '0;
        end else begin
            o_route.x_en       <= x_use;
            o_route.y_en       <= i_req_valid && y_use;
            o_route.force_zero <= i_req_valid && is_data && !psv_hit && (mac_wrong || !ea_mapped);
            o_route.visibility_enable        <= psv_hit;
            o_route.extra      <= psv_hit ? psv_penalty(i_req.cls, i_req.in_repeat, i_req.rpt_edge)
                                          : prog_space_pkg::PEN_NONE;
        end
    end

    // Read answer two cycles after the request
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rsp       <= '0;
            last_addr_q <= 24'h000000;
        end else begin
            o_rsp.valid <= rd_pend_q;
            o_rsp.data  <= rd_pend_q ? rd_steer : 16'h0000;
            if (rd_pend_q || o_pm_wr) begin
                last_addr_q <= o_pm_addr;
            end
        end
    end

    // Bus slave: address and data taken in either order
    wire logic aw_take  = s_axi_awvalid && s_axi_awready;
    wire logic w_take   = s_axi_wvalid && s_axi_wready;
    wire logic aw_have  = aw_held_q || aw_take;
    wire logic w_have   = w_held_q || w_take;
    wire logic wr_fire  = aw_have && w_have && !bvalid_q;
    wire logic bvalid_d = wr_fire || (bvalid_q && !s_axi_bready);
    wire logic [3:0]  wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
    wire logic [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
    wire logic [3:0]  wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
    wire logic wr_lane0 = wr_fire && wr_strb[0];
    wire logic wr_ok    = (wr_addr == prog_space_pkg::CORE_CONTROL_OFS)
                       || (wr_addr == prog_space_pkg::PAGE_WINDOW_OFS)
                       || (wr_addr == prog_space_pkg::TABLE_PAGE_OFS);

    // Write channel holding and response
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= prog_space_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            aw_held_q <= aw_have && !wr_fire;
            w_held_q  <= w_have && !wr_fire;
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? prog_space_pkg::RESP_OKAY : prog_space_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Control registers; only the low byte lane carries bits
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            core_ctl_q <= prog_space_pkg::CORE_CONTROL_RST;
            page_win_q <= prog_space_pkg::PAGE_WINDOW_RST;
            tbl_page_q <= prog_space_pkg::TABLE_PAGE_RST;
        end else if (wr_lane0) begin
            if (wr_addr == prog_space_pkg::CORE_CONTROL_OFS) begin
                core_ctl_q <= {7'h00, wr_data[prog_space_pkg::VIS_ENABLE_BIT]};
            end
            if (wr_addr == prog_space_pkg::PAGE_WINDOW_OFS) begin
                page_win_q <= wr_data[7:0];
            end
            if (wr_addr == prog_space_pkg::TABLE_PAGE_OFS) begin
                tbl_page_q <= wr_data[7:0];
            end
        end
    end

    // Read decode
    wire logic ar_take = s_axi_arvalid && s_axi_arready;
    logic [31:0] rd_word;
    logic        rd_ok;
    always_comb begin
        rd_word = 32'h00000000;
        rd_ok   = 1'b1;
        case (s_axi_araddr)
            prog_space_pkg::CORE_CONTROL_OFS: rd_word = {24'h000000, core_ctl_q};
            prog_space_pkg::PAGE_WINDOW_OFS:  rd_word = {24'h000000, page_win_q};
            prog_space_pkg::TABLE_PAGE_OFS:   rd_word = {24'h000000, tbl_page_q};
            prog_space_pkg::LAST_ADDR_OFS:    rd_word = {8'h00, last_addr_q};
            default:                          rd_ok   = 1'b0;
        endcase
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= prog_space_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_ok ? prog_space_pkg::RESP_OKAY : prog_space_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Ready flags registered so outputs stay flop driven
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= !(aw_have && !wr_fire) && !bvalid_d;
            s_axi_wready  <= !(w_have && !wr_fire) && !bvalid_d;
            s_axi_arready <= !(ar_take || (rvalid_q && !s_axi_rready));
        end
    end

    assign o_pc         = pc_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

endmodule : prog_space_access

`default_nettype wire

// >>> sim/prog_space_checker.sv
`timescale 1ns/10ps
`default_nettype none

module prog_space_checker (
    // Clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_sys_rst,
    // Program counter
    input  wire logic                      i_pc_step,
    input  wire logic                      i_pc_load,
    input  wire logic [22:0]               o_pc,
    // Core request and routing
    input  wire logic                      i_req_valid,
    input  wire prog_space_pkg::req_type   i_req,
    input  wire prog_space_pkg::route_type o_route,
    input  wire logic [23:0]               o_pm_addr,
    input  wire logic                      o_pm_rd
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // Window read taken at one edge, flagged at the next with its fetch alongside
    sequence vis_req;
        (i_req_valid && i_req.op == prog_space_pkg::OP_DATA_RD) ##1 o_route.visibility_enable;
    endsequence
    sequence vis_fetch;
        o_pm_rd && !o_pm_addr[23] && o_pm_addr[14:0] == $past(i_req.ea[14:0]);
    endsequence

    // Table ops outside the window keep the low word direct
    wire logic tbl_op = i_req.op inside {prog_space_pkg::OP_TRD_LO, prog_space_pkg::OP_TRD_HI,
                                         prog_space_pkg::OP_TWR_LO, prog_space_pkg::OP_TWR_HI};

    pc_step_a: assert property (i_pc_step && !i_pc_load |=> o_pc == $past(o_pc) + 23'h000002)
        else $error("pc did not advance by two");
    redirect_msb_a: assert property (vis_req |-> $past(i_req.ea[15]))
        else $error("window redirect without address msb");
    table_no_psv_a: assert property (i_req_valid && tbl_op |=> !o_route.visibility_enable)
        else $error("window active during table access");
    page_fetch_a: assert property (vis_req |-> vis_fetch)
        else $error("window fetch missing or bit 23 set");
    short_pen_a: assert property (vis_req ##0 (!$past(i_req.in_repeat)
                                  && $past(i_req.cls) != prog_space_pkg::CLS_OTHER)
                                  |-> o_route.extra == prog_space_pkg::PEN_SHORT)
        else $error("short penalty wrong");
    long_pen_a: assert property (vis_req ##0 (!$past(i_req.in_repeat)
                                 && $past(i_req.cls) == prog_space_pkg::CLS_OTHER)
                                 |-> o_route.extra == prog_space_pkg::PEN_LONG)
        else $error("long penalty wrong");
    repeat_pen_a: assert property (vis_req ##0 $past(i_req.in_repeat)
                                   |-> o_route.extra == ($past(i_req.rpt_edge) ? 2'h2 : 2'h0))
        else $error("repeat penalty wrong");
    y_only_mac_a: assert property (o_route.y_en |-> $past(i_req.mac) && !$past(i_req.ea[15]))
        else $error("y path used outside mac or upper half");
endmodule : prog_space_checker

`default_nettype wire

// >>> sim/prog_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

module prog_mem_model (
    // Clock
    input  wire logic        i_clk,
    // Memory port
    input  wire logic [23:0] i_addr,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic [2:0]  i_be,
    input  wire logic [23:0] i_wdata,
    output var  logic [23:0] o_rdata
);
    logic [23:0] mem [logic [22:0]];

    // Unwritten words follow a fixed pattern of the word address
    function automatic logic [23:0] fill(input logic [23:0] a);
        return {a[8:1] ^ 8'h96, a[16:1] ^ 16'h5a3c};
    endfunction : fill

    // Read answers while the address stands; idle bus shows the inverse so stale data never matches
    always @* begin
        o_rdata = ~fill(i_addr);
        if (i_rd) o_rdata = mem.exists(i_addr[23:1]) ? mem[i_addr[23:1]] : fill(i_addr);
    end
    always @(posedge i_clk) begin
        if (i_wr) begin
            if (!mem.exists(i_addr[23:1])) mem[i_addr[23:1]] = fill(i_addr);
            for (int b = 0; b < 3; b++) begin
                if (i_be[b]) mem[i_addr[23:1]][8*b +: 8] = i_wdata[8*b +: 8];
            end
        end
    end
endmodule : prog_mem_model

`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_pc_step = 1'b0, i_pc_load = 1'b0, i_req_valid = 1'b0;
    logic [22:0] i_pc_value = 23'h000000, o_pc;
    prog_space_pkg::req_type   i_req = '0, r;
    prog_space_pkg::route_type o_route, rt;
    prog_space_pkg::rsp_type   o_rsp;
    logic [23:0] o_pm_addr, o_pm_wdata, i_pm_rdata;
    logic [2:0]  o_pm_be;
    logic o_pm_rd, o_pm_wr, o_pm_cfg, cfg_seen = 1'b0;
    logic awv = 0, awr, wv = 0, wr, bv, br = 0, arv = 0, arr, rv, rr = 0;
    logic [3:0] awa = 4'h0, ara = 4'h0, ws = 4'h0;
    logic [31:0] wd = 32'h0, rd, v;
    logic [1:0] bresp, rresp;
    logic [15:0] d, e, m;
    int bad_count = 0, samples_checked = 0;
    logic [1:0] pen [6] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0};

    // Free-running 100 MHz clock
    always #5 i_clk = ~i_clk;

    prog_space_access dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pc_step(i_pc_step), .i_pc_load(i_pc_load),
        .i_pc_value(i_pc_value), .o_pc(o_pc), .i_req_valid(i_req_valid), .i_req(i_req), .o_route(o_route),
        .o_rsp(o_rsp), .o_pm_addr(o_pm_addr), .o_pm_rd(o_pm_rd), .o_pm_wr(o_pm_wr), .o_pm_be(o_pm_be),
        .o_pm_wdata(o_pm_wdata), .o_pm_cfg(o_pm_cfg), .i_pm_rdata(i_pm_rdata), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd),
        .s_axi_rresp(rresp));
    prog_mem_model pm (.i_clk(i_clk), .i_addr(o_pm_addr), .i_rd(o_pm_rd), .i_wr(o_pm_wr), .i_be(o_pm_be),
        .i_wdata(o_pm_wdata), .o_rdata(i_pm_rdata));

    // Latch the space select seen on any memory fetch
    always @(posedge i_clk) if (o_pm_rd === 1'b1) cfg_seen <= o_pm_cfg;

    function automatic logic [23:0] fill(input logic [23:0] a);
        return {a[8:1] ^ 8'h96, a[16:1] ^ 16'h5a3c};
    endfunction : fill

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] dat);
        int n = 0;
        @(posedge i_clk);
        awv <= 1; awa <= a; wv <= 1; wd <= dat; ws <= 4'hf; br <= 1;
        do begin
            @(posedge i_clk);
            if (awr === 1'b1) awv <= 0;
            if (wr === 1'b1) wv <= 0;
            n++;
        end while (bv !== 1'b1 && n < 50);
        br <= 0;
        chk("bresp", 3'h4, {bv, bresp});
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] dat);
        int n = 0;
        @(posedge i_clk);
        arv <= 1; ara <= a; rr <= 1;
        do begin
            @(posedge i_clk);
            if (arr === 1'b1) arv <= 0;
            n++;
        end while (rv !== 1'b1 && n < 50);
        dat = rd;
        chk("rresp", 3'h4, {rv, rresp});
        rr <= 0;
    endtask : axi_rd

    // One request cycle, route sampled mid-cycle, then wait for the answer
    task automatic do_req(input prog_space_pkg::req_type q, output logic [15:0] dat);
        int n = 0;
        @(posedge i_clk);
        i_req_valid <= 1; i_req <= q;
        @(posedge i_clk);
        i_req_valid <= 0;
        @(negedge i_clk);
        rt = o_route;
        while (o_rsp.valid !== 1'b1 && n < 20) begin
            @(negedge i_clk);
            n++;
        end
        dat = o_rsp.data;
    endtask : do_req

    task automatic stop_test;
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    // Watchdog well beyond the few hundred cycles of the tests
    initial begin
        #200us;
        bad_count++;
        stop_test();
    end

    initial begin
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 0;
        axi_rd(prog_space_pkg::CORE_CONTROL_OFS, v); chk("core_control_reg", 0, v[7:0]);
        axi_rd(prog_space_pkg::PAGE_WINDOW_OFS, v); chk("program_page_window", 0, v[7:0]);
        axi_wr(prog_space_pkg::PAGE_WINDOW_OFS, 32'h12);
        axi_rd(prog_space_pkg::PAGE_WINDOW_OFS, v); chk("program_page_window", 32'h12, v);
        $display("test 1 done");
        // Program counter load then three steps
        @(posedge i_clk); i_pc_load <= 1; i_pc_value <= 23'h000100;
        @(posedge i_clk); i_pc_load <= 0; i_pc_step <= 1;
        repeat (3) @(posedge i_clk);
        i_pc_step <= 0;
        @(negedge i_clk); chk("pc", 23'h000106, o_pc);
        $display("test 2 done");
        // Table reads in all lanes, window enabled to prove it is bypassed
        axi_wr(prog_space_pkg::CORE_CONTROL_OFS, 32'h1);
        axi_wr(prog_space_pkg::TABLE_PAGE_OFS, 32'h03);
        for (int k = 0; k < 8; k++) begin
            r = '0;
            r.op = k[2] ? prog_space_pkg::OP_TRD_HI : prog_space_pkg::OP_TRD_LO;
            r.byte_mode = k[1];
            r.ea = {k[0], 15'h1234} | 16'(k[1] & k[0]);
            v = {8'h0, fill({8'h03, r.ea})};
            m = r.byte_mode ? 16'h00ff : 16'hffff;
            if (!k[2]) e = (r.byte_mode && r.ea[0]) ? v[15:8] : v[15:0];
            else e = (r.byte_mode && r.ea[0]) ? 16'h0 : {8'h0, v[23:16]};
            do_req(r, d);
            chk("table data", e & m, d & m);
            chk("table window", 0, rt.visibility_enable);
            chk("user space", 0, cfg_seen);
        end
        $display("test 3 done");
        // Window reads with every penalty case
        for (int k = 0; k < 6; k++) begin
            r = '0; r.op = prog_space_pkg::OP_DATA_RD; r.ea = 16'h8abc;
            r.cls = prog_space_pkg::cls_type'(k[1:0] | {2{k > 3}});
            r.in_repeat = k > 3; r.rpt_edge = k == 4;
            do_req(r, d);
            chk("window data", fill({1'b0, 8'h12, 15'h0abc}) & 24'hffff, d);
            chk("window flag", 1, rt.visibility_enable);
            chk("penalty", pen[k], rt.extra);
        end
        r.ea = 16'h7abc; do_req(r, d); chk("low half window", 0, rt.visibility_enable);
        axi_wr(prog_space_pkg::CORE_CONTROL_OFS, 32'h0);
        r.ea = 16'h8abc; do_req(r, d); chk("disabled window", 0, rt.visibility_enable);
        $display("test 4 done");
        // Dual operand reads through the two pointer pairs
        r = '0; r.op = prog_space_pkg::OP_DATA_RD; r.ea = 16'h0090; r.mac = 1; r.ptr = prog_space_pkg::PTR_Y_A;
        do_req(r, d); chk("y path", 1, rt.y_en);
        r.ptr = prog_space_pkg::PTR_X_B;
        do_req(r, d); chk("x ptr into y", 1, rt.force_zero);
        r.mac = 0;
        do_req(r, d); chk("plain read y path", 0, rt.y_en); chk("plain read x", 1, rt.x_en);
        $display("test 5 done");
        // Configuration space select
        axi_wr(prog_space_pkg::TABLE_PAGE_OFS, 32'h83);
        r = '0; r.op = prog_space_pkg::OP_TRD_LO; r.ea = 16'h0010;
        do_req(r, d); chk("config space", 1, cfg_seen);
        r = '0; r.op = prog_space_pkg::OP_TWR_LO; r.ea = 16'h0020; r.wdata = 16'hbeef; do_req(r, d);
        r.op = prog_space_pkg::OP_TWR_HI; r.wdata = 16'h00a5; do_req(r, d);
        r.op = prog_space_pkg::OP_TRD_LO; do_req(r, d); chk("written low", 16'hbeef, d);
        r.op = prog_space_pkg::OP_TRD_HI; do_req(r, d); chk("written high", 16'h00a5, d);
        $display("test 6 done");
        stop_test();
    end
endmodule : testbench

bind prog_space_access prog_space_checker chk_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pc_step(i_pc_step),
    .i_pc_load(i_pc_load), .o_pc(o_pc), .i_req_valid(i_req_valid), .i_req(i_req), .o_route(o_route),
    .o_pm_addr(o_pm_addr), .o_pm_rd(o_pm_rd));

`default_nettype wire
